// [verilog/port_a_pkg.sv]
package port_a_pkg;

   localparam int unsigned PIN_COUNT = 6;
   localparam int unsigned TIMER_PIN = 4;
   localparam int unsigned SS_PIN    = 5;

   // Printed register indices; byte address is four times the index
   localparam logic [31:0] IDX_PORT_PIN_DATA        = 32'h0000_0005;
   localparam logic [31:0] IDX_PORT_DIRECTION       = 32'h0000_0085;
   localparam logic [31:0] IDX_COMPARATOR_CONTROL   = 32'h0000_009C;
   localparam logic [31:0] IDX_CONVERTER_PIN_CONFIG = 32'h0000_009F;
   localparam logic [31:0] IDX_PORT_BIT_SET         = 32'h0000_0006;
   localparam logic [31:0] IDX_PORT_BIT_CLEAR       = 32'h0000_0007;

   localparam logic [31:0] ADDR_PORT_PIN_DATA        = IDX_PORT_PIN_DATA << 2;
   localparam logic [31:0] ADDR_PORT_DIRECTION       = IDX_PORT_DIRECTION << 2;
   localparam logic [31:0] ADDR_COMPARATOR_CONTROL   = IDX_COMPARATOR_CONTROL << 2;
   localparam logic [31:0] ADDR_CONVERTER_PIN_CONFIG = IDX_CONVERTER_PIN_CONFIG << 2;
   localparam logic [31:0] ADDR_PORT_BIT_SET         = IDX_PORT_BIT_SET << 2;
   localparam logic [31:0] ADDR_PORT_BIT_CLEAR       = IDX_PORT_BIT_CLEAR << 2;

   // Reset values
   localparam logic [5:0] LATCH_RST = 6'h00;
   localparam logic [5:0] DIR_RST   = 6'h3F;
   localparam logic [5:0] CMP_RST   = 6'h07;
   localparam logic [5:0] ADC_RST   = 6'h00;

   // Comparator control fields (writable part is bits 5:0)
   localparam int unsigned CMP_TWO_RESULT = 7;
   localparam int unsigned CMP_ONE_RESULT = 6;
   localparam int unsigned CMP_C2INV = 5;
   localparam int unsigned CMP_C1INV = 4;
   localparam int unsigned CMP_CM_LSB = 0;
   localparam logic [2:0]  CM_OFF = 3'h7;
   localparam logic [2:0]  CM_OUT = 3'h6;

   // Converter pin config fields (stored as {adfm, adcs2, pcfg})
   localparam int unsigned ADC_ADFM = 7;
   localparam int unsigned ADC_ADCS2 = 6;
   localparam int unsigned ADC_PCFG_LSB = 0;

   // Pin configuration codes, bit n set when code n makes the pin(s) digital
   localparam logic [15:0] LOW_PINS_DIGITAL_CODES = 16'h00C0;
   localparam logic [15:0] PIN_FIVE_DIGITAL_CODES = 16'hA0F0;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;

endpackage : port_a_pkg

// [verilog/port_a_mode_decode.sv]
`timescale 1ns/100ps
`default_nettype none
module port_a_mode_decode
   import port_a_pkg::*;
(
   input  wire logic [3:0] pin_config_field,
   input  wire logic [2:0] comparator_mode,
   output logic      [5:0] analog_mask,
   output logic            compare_out_en
);

   logic comparator_on;

   always_comb begin
      comparator_on  = (comparator_mode != CM_OFF);
      compare_out_en = (comparator_mode == CM_OUT);
      // Comparator inputs also claim the low pins while it runs
      analog_mask[3:0] = (comparator_on || !LOW_PINS_DIGITAL_CODES[pin_config_field]) ? 4'hF : 4'h0;
      analog_mask[4]   = 1'b0;
      analog_mask[5]   = !PIN_FIVE_DIGITAL_CODES[pin_config_field];
   end

endmodule // port_a_mode_decode
`default_nettype wire

// [verilog/port_a_pin.sv]
`timescale 1ns/100ps
`default_nettype none
module port_a_pin
   import port_a_pkg::*;
#(
   parameter bit OPEN_DRAIN = 1'b0
) (
   input  wire logic latch_bit,
   input  wire logic dir_bit,
   input  wire logic alt_out_en,
   input  wire logic alt_out_val,
   input  wire logic alt_in_en,
   output logic      drive_val,
   output logic      drive_en
);

   logic value;
   logic enable;

   always_comb begin
      value  = alt_out_en ? alt_out_val : latch_bit;
      // Direction bit gates the driver even on analog pins
      enable = !dir_bit && !alt_in_en;
      if (OPEN_DRAIN) begin
         drive_val = 1'b0;
         drive_en  = enable && !value;
      end else begin
         drive_val = value;
         drive_en  = enable;
      end
   end

endmodule // port_a_pin
`default_nettype wire

// [verilog/port_a_top.sv]
// Overview of operation
// - Six bidirectional pins, each usable as digital input or output.
// - Direction bit 1 turns the pin driver off; pin is input.
// - Direction bit 0 drives the pin from its output latch bit.
// - Data reads return pin levels; data writes only update the latch.
// - Set and clear writes are read-modify-write: sample pins, alter bits, store whole latch.
// - Pin 4 is I/O, timer clock input or comparator one output; open-drain.
// - Pin 5 is I/O, analog input, serial slave select or comparator two output.
// - Converter config and comparator control bits choose analog or digital per pin.
// - After reset analog-capable pins are analog and read as zero.
// - After reset comparators are off.
// - Direction bits control drivers even on analog pins.
// - Two upper bits of data and direction registers read zero.
// - An enabled timer or slave select input only turns its pin driver off; data reads still see the pin.
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module port_a_top
   import port_a_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [5:0]  pin_in,
   output logic      [5:0]  pin_out,
   output logic      [5:0]  pin_oe,
   input  wire logic        comparator_one_result,
   input  wire logic        comparator_two_result,
   input  wire logic        timer_clock_select,
   input  wire logic        serial_slave_select_enable,
   output logic             timer_zero_ext_clock,
   output logic             serial_slave_select,
   output logic      [5:0]  analog_select
);

   typedef struct packed {
      logic [5:0]  latch;
      logic [5:0]  dir;
      logic [5:0]  cmp;
      logic [5:0]  adc;
      logic [5:0]  dsel;
      logic [31:0] rdata;
      logic        ready;
      logic        resp;
      logic [5:0]  pout;
      logic [5:0]  poe;
      logic        tmr_clk;
      logic        ss;
      logic [5:0]  ana;
   } state_s;

   // Data phase select, one bit per decoded register
   localparam int unsigned S_DATA = 0;
   localparam int unsigned S_DIR  = 1;
   localparam int unsigned S_CMP  = 2;
   localparam int unsigned S_ADC  = 3;
   localparam int unsigned S_SET  = 4;
   localparam int unsigned S_CLR  = 5;

   state_s      state_q;
   state_s      state_d;
   logic [5:0]  analog_mask;
   logic        compare_out_en;
   logic [5:0]  drive_val;
   logic [5:0]  drive_en;
   logic [5:0]  alt_out_en;
   logic [5:0]  alt_out_val;
   logic [5:0]  alt_in_en;
   logic [5:0]  pin_levels;
   logic        c1_out;
   logic        c2_out;
   logic        addr_phase;
   logic [5:0]  sel;
   logic [31:0] rd_mux;
   logic [7:0]  cmp_read;
   logic [7:0]  adc_read;

   port_a_mode_decode u_decode (
      .pin_config_field (state_q.adc[ADC_PCFG_LSB +: 4]),
      .comparator_mode  (state_q.cmp[CMP_CM_LSB +: 3]),
      .analog_mask      (analog_mask),
      .compare_out_en   (compare_out_en)
   );

   always_comb begin
      c1_out = comparator_one_result ^ state_q.cmp[CMP_C1INV];
      c2_out = comparator_two_result ^ state_q.cmp[CMP_C2INV];
      alt_out_en  = '0;
      alt_out_val = '0;
      alt_in_en   = '0;
      alt_out_en[TIMER_PIN]  = compare_out_en;
      alt_out_val[TIMER_PIN] = c1_out;
      alt_out_en[SS_PIN]     = compare_out_en;
      alt_out_val[SS_PIN]    = c2_out;
      // Input peripherals win the pin so nothing fights the external source
      alt_in_en[TIMER_PIN]   = timer_clock_select;
      alt_in_en[SS_PIN]      = serial_slave_select_enable;
   end

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         port_a_pin #(
            .OPEN_DRAIN (gi == TIMER_PIN)
         ) u_pin (
            .latch_bit   (state_q.latch[gi]),
            .dir_bit     (state_q.dir[gi]),
            .alt_out_en  (alt_out_en[gi]),
            .alt_out_val (alt_out_val[gi]),
            .alt_in_en   (alt_in_en[gi]),
            .drive_val   (drive_val[gi]),
            .drive_en    (drive_en[gi])
         );
      end
   endgenerate

   always_comb begin
      // Analog pins read as zero
      pin_levels = pin_in & ~analog_mask;
      addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
      sel = '0;
      sel[S_DATA] = (haddr == ADDR_PORT_PIN_DATA);
      sel[S_DIR]  = (haddr == ADDR_PORT_DIRECTION);
      sel[S_CMP]  = (haddr == ADDR_COMPARATOR_CONTROL);
      sel[S_ADC]  = (haddr == ADDR_CONVERTER_PIN_CONFIG);
      sel[S_SET]  = (haddr == ADDR_PORT_BIT_SET);
      sel[S_CLR]  = (haddr == ADDR_PORT_BIT_CLEAR);
      cmp_read = {c2_out, c1_out, state_q.cmp};
      adc_read = {state_q.adc[5:4], 2'h0, state_q.adc[3:0]};
      rd_mux = '0;
      if (sel[S_DATA] || sel[S_SET] || sel[S_CLR]) begin
         rd_mux[5:0] = pin_levels;
      end else if (sel[S_DIR]) begin
         rd_mux[5:0] = state_q.dir;
      end else if (sel[S_CMP]) begin
         rd_mux[7:0] = cmp_read;
      end else if (sel[S_ADC]) begin
         rd_mux[7:0] = adc_read;
      end
   end

   always_comb begin
      state_d = state_q;
      state_d.ready = 1'b1;
      state_d.resp  = 1'b0;
      // Data phase writes; latch holds otherwise, whatever the direction
      if (state_q.dsel[S_DATA]) begin
         state_d.latch = hwdata[5:0];
      end
      // Set and clear start from pin levels, so input pins copy their level
      // into the latch and analog pins clear it: the usual read-modify-write hazard
      if (state_q.dsel[S_SET]) begin
         state_d.latch = pin_levels | hwdata[5:0];
      end
      if (state_q.dsel[S_CLR]) begin
         state_d.latch = pin_levels & ~hwdata[5:0];
      end
      if (state_q.dsel[S_DIR]) begin
         state_d.dir = hwdata[5:0];
      end
      if (state_q.dsel[S_CMP]) begin
         state_d.cmp = hwdata[5:0];
      end
      if (state_q.dsel[S_ADC]) begin
         state_d.adc = {hwdata[ADC_ADFM], hwdata[ADC_ADCS2], hwdata[ADC_PCFG_LSB +: 4]};
      end
      // Address phase: capture select and read data for a zero-wait answer
      if (hready) begin
         state_d.dsel = '0;
         if (addr_phase) begin
            if (hwrite) begin
               state_d.dsel = sel;
            end else begin
               state_d.rdata = rd_mux;
            end
         end
      end
      state_d.pout    = drive_val;
      state_d.poe     = drive_en;
      state_d.tmr_clk = timer_clock_select && pin_in[TIMER_PIN];
      state_d.ss      = serial_slave_select_enable ? pin_in[SS_PIN] : 1'b1;
      state_d.ana     = analog_mask;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q.latch   <= LATCH_RST;
         state_q.dir     <= DIR_RST;
         state_q.cmp     <= CMP_RST;
         state_q.adc     <= ADC_RST;
         state_q.dsel    <= '0;
         state_q.rdata   <= '0;
         state_q.ready   <= 1'b1;
         state_q.resp    <= 1'b0;
         state_q.pout    <= '0;
         state_q.poe     <= '0;
         state_q.tmr_clk <= 1'b0;
         state_q.ss      <= 1'b1;
         state_q.ana     <= '1;
      end else begin
         state_q <= state_d;
      end
   end

   assign hrdata               = state_q.rdata;
   assign hreadyout            = state_q.ready;
   assign hresp                = state_q.resp;
   assign pin_out              = state_q.pout;
   assign pin_oe               = state_q.poe;
   assign timer_zero_ext_clock = state_q.tmr_clk;
   assign serial_slave_select  = state_q.ss;
   assign analog_select        = state_q.ana;

endmodule // port_a_top
`default_nettype wire

// [sim/port_a_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module port_a_chk
   import port_a_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic [5:0]  pin_in,
   input wire logic [5:0]  pin_out,
   input wire logic [5:0]  pin_oe,
   input wire logic        timer_clock_select,
   input wire logic        serial_slave_select_enable,
   input wire logic        timer_zero_ext_clock,
   input wire logic        serial_slave_select,
   input wire logic [5:0]  analog_select
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic rd_a;
   assign rd_a = hsel && hready && htrans[1] && !hwrite;
   property p_od; !pin_out[4]; endproperty
   a_od: assert property (p_od) else $error("pin four driven high");
   property p_tmr_oe; timer_clock_select |=> !pin_oe[4]; endproperty
   a_tmr_oe: assert property (p_tmr_oe) else $error("timer pin driven");
   property p_ss_oe; serial_slave_select_enable |=> !pin_oe[5]; endproperty
   a_ss_oe: assert property (p_ss_oe) else $error("select pin driven");
   property p_ss_val; serial_slave_select_enable |=> serial_slave_select == $past(pin_in[5]); endproperty
   a_ss_val: assert property (p_ss_val) else $error("select level wrong");
   property p_ss_idle; !serial_slave_select_enable |=> serial_slave_select; endproperty
   a_ss_idle: assert property (p_ss_idle) else $error("select not idle");
   property p_tclk; 1'b1 |=> timer_zero_ext_clock == $past(pin_in[4] && timer_clock_select); endproperty
   a_tclk: assert property (p_tclk) else $error("timer clock wrong");
   property p_up;
      rd_a && (haddr == ADDR_PORT_PIN_DATA || haddr == ADDR_PORT_DIRECTION) |=> hrdata[31:6] == 26'h0;
   endproperty
   a_up: assert property (p_up) else $error("upper bits set");
   property p_rd4; rd_a && haddr == ADDR_PORT_PIN_DATA |=> hrdata[4] == $past(pin_in[4]); endproperty
   a_rd4: assert property (p_rd4) else $error("read not pin level");
   property p_por; $fell(srst) |-> analog_select == 6'h3F ##1 analog_select == 6'h2F; endproperty
   a_por: assert property (p_por) else $error("analog pins after reset");
   c_rd: cover property (rd_a && haddr == ADDR_PORT_PIN_DATA);
   c_ss: cover property (serial_slave_select_enable && !pin_in[5]);
   c_tm: cover property (timer_clock_select && pin_in[4]);
endmodule // port_a_chk
bind port_a_top port_a_chk u_chk (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .pin_in,
   .pin_out, .pin_oe, .timer_clock_select, .serial_slave_select_enable, .timer_zero_ext_clock,
   .serial_slave_select, .analog_select);
`default_nettype wire

// [sim/port_a_ext.sv]
`timescale 1ns/100ps
`default_nettype none
module port_a_ext (
   input  wire logic [5:0] pin_out,
   input  wire logic [5:0] pin_oe,
   input  wire logic [5:0] ext_level,
   output logic      [5:0] pin_in
);
   // Released pins follow the outside circuit, never the last driven value
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // port_a_ext
`default_nettype wire

// [sim/tb_six_bit_bidirectional_port_a.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_six_bit_bidirectional_port_a
   import port_a_pkg::*;
   ;
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %0t got %h exp %h", $time, g, e); end end
   logic        clk, srst, hsel, hwrite, c1, c2, tse, sse, hreadyout, hresp, tzc, ssel;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd, x, r;
   logic [5:0]  pin_in, pin_out, pin_oe, asel, ext, lat, dir, lv, m;
   int          err_count, comparisons;
   localparam logic [15:0] D5 = 16'hA0F0;
   localparam logic [15:0] D03 = 16'h00C0;
   port_a_top DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .comparator_one_result(c1),
      .comparator_two_result(c2), .timer_clock_select(tse), .serial_slave_select_enable(sse),
      .timer_zero_ext_clock(tzc), .serial_slave_select(ssel), .analog_select(asel));
   port_a_ext u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
   function automatic logic [31:0] xs();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   // Open drain pin four only pulls low; peripherals take their pins as inputs
   function automatic logic [5:0] eoe();
      return ~dir & ~{sse, tse | lat[4], 4'h0};
   endfunction
   function automatic logic [5:0] eout();
      return {lat[5], 1'b0, lat[3:0]};
   endfunction
   function automatic logic [5:0] lvl();
      return (eoe() & eout()) | (~eoe() & ext);
   endfunction
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      haddr <= a;
      hwrite <= w;
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic print_verdict();
      $display("comparisons %0d errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #1000000;
      err_count++;
      print_verdict();
   end
   initial begin
      x = 32'h2498AB66;
      {srst, hsel, hwrite, tse, sse, c1, c2} = 7'b1000010;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      ext = 6'h3F;
      err_count = 0;
      comparisons = 0;
      lat = 6'h00;
      dir = 6'h3F;
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      bus(0, ADDR_PORT_DIRECTION, 0);
      `CHK(rd, 32'h3F)
      bus(0, ADDR_COMPARATOR_CONTROL, 0);
      `CHK(rd, 32'h47)
      bus(0, ADDR_PORT_PIN_DATA, 0);
      `CHK(rd, 32'h10)
      bus(1, ADDR_COMPARATOR_CONTROL, 32'h37);
      bus(0, ADDR_COMPARATOR_CONTROL, 0);
      `CHK(rd, 32'hB7)
      bus(1, ADDR_COMPARATOR_CONTROL, 32'h07);
      bus(1, 32'h100, 32'hFF);
      bus(0, 32'h100, 0);
      `CHK(rd, 32'h0)
      for (int c = 0; c < 16; c++) begin // Analog pins read as zero and show on analog_select
         bus(1, ADDR_CONVERTER_PIN_CONFIG, 32'(c));
         bus(0, ADDR_PORT_PIN_DATA, 0);
         m = {~D5[c], 1'b0, {4{~D03[c]}}};
         `CHK(rd, {26'h0, ~m})
         `CHK(asel, m)
      end
      bus(1, ADDR_CONVERTER_PIN_CONFIG, 32'h6); // Code 011x keeps slave select legal
      // Latch is written before the direction flips, so held values must show
      for (int i = 0; i < 24; i++) begin
         r = xs();
         ext <= r[5:0];
         {c2, c1, sse, tse} <= r[9:6];
         lat = r[21:16];
         m = r[27:22];
         bus(1, ADDR_PORT_PIN_DATA, {26'h0, lat});
         dir = r[15:10];
         bus(1, ADDR_PORT_DIRECTION, {26'h0, dir});
         lv = lvl();
         lat = r[28] ? (lv | m) : (lv & ~m);
         bus(1, r[28] ? ADDR_PORT_BIT_SET : ADDR_PORT_BIT_CLEAR, {26'h0, m});
         bus(0, ADDR_PORT_PIN_DATA, 0);
         `CHK(rd, {26'h0, lvl()})
         `CHK(pin_oe, eoe())
         `CHK(pin_out, eout())
         lv = lvl();
         `CHK(tzc, tse & lv[4])
         `CHK(ssel, sse ? lv[5] : 1'b1)
         `CHK(hresp, 1'b0)
      end
      // Comparator output mode takes pins four and five and claims the low pins
      {c2, c1, sse, tse} <= 4'b1000;
      bus(1, ADDR_COMPARATOR_CONTROL, {29'h0, CM_OUT});
      dir = 6'h0F;
      bus(1, ADDR_PORT_DIRECTION, 32'h0F);
      bus(0, ADDR_PORT_PIN_DATA, 0);
      `CHK(pin_oe, 6'h30)
      `CHK(pin_out, {2'b10, lat[3:0]})
      `CHK(asel, 6'h0F)
      `CHK(rd, 32'h20)
      bus(1, ADDR_COMPARATOR_CONTROL, {29'h0, CM_OFF});
      bus(1, ADDR_CONVERTER_PIN_CONFIG, 32'h0);
      dir = 6'h30;
      bus(1, ADDR_PORT_DIRECTION, 32'h30);
      bus(0, ADDR_PORT_PIN_DATA, 0);
      `CHK(pin_oe, eoe())
      `CHK(rd, {26'h0, lvl() & 6'h10})
      print_verdict();
   end
endmodule // tb_six_bit_bidirectional_port_a
`default_nettype wire
